// ### design/rdcr_top.sv
// Redriver configuration: serial slave, register bank, per-channel control
//
// Function
// - While cable_present_n is high every channel is powered down, whatever the registers say.
// - While cable_present_n is low channels run unless powered down by register.
// - Either the pin or the power-down register may shut channels down.
// - Byte 2 bits 7..4 power down channels 3..0 when one; bits 3..0 are plain storage; reset 0.
// - Flat-gain code is two bits per channel, 00..11 for -3.5, -1.5, 0.5, 2.5 dB.
// - Swing code is two bits per channel, 00..11 for 920, 1040, 1280, 1370 mV limits.
// - Equalizer code is four bits per channel, boost rising with the code.
// - Bus address is 111, straps 3..1, then 1 on the small package or strap 0; LSB 1 reads.
// - Bytes 3 to 6 hold channels 0 to 3: eq 7:4, gain 3:2, swing 1:0, reset 0.
// - config_mode_select high enables the serial slave; low selects strap mode.
// - In strap mode the strap codes drive all four channels alike.
// - Register reset low returns all registers to their defaults.
// - Bytes are accessed in ascending order from byte 0; a transfer may stop after any byte.
`timescale 1ns/1ps
module rdcr_top
#(
    parameter bit SMALL_PKG = 1'b0
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Serial bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Mode, presence and address straps
    input wire logic cable_present_n,
    input wire logic config_mode_select,
    input wire logic [3:0] addr_strap,
    // Code straps; flat_gain_code[1] is register reset in register mode
    input wire logic [rdcr_pkg::EQ_W-1:0] equalizer_boost_code,
    input wire logic [rdcr_pkg::SW_W-1:0] output_swing_code,
    input wire logic [rdcr_pkg::FG_W-1:0] flat_gain_code,
    // Per-channel settings
    output logic [rdcr_pkg::NUM_CH*rdcr_pkg::EQ_W-1:0] ch_eq,
    output logic [rdcr_pkg::NUM_CH*rdcr_pkg::FG_W-1:0] ch_fg,
    output logic [rdcr_pkg::NUM_CH*rdcr_pkg::SW_W-1:0] ch_sw,
    output logic [rdcr_pkg::NUM_CH-1:0] ch_enable,
    output logic global_pd
);
    import rdcr_pkg::*;

    if (NUM_CH != 4)
    begin : g_bad_ch
        $error("rdcr_top serves exactly four channels");
    end

    // Pin sampling and bus conditions
    logic scl_q, scl_p, sda_q, sda_p;
    wire scl_rise = scl_q & ~scl_p;
    wire scl_fall = ~scl_q & scl_p;
    wire bus_start = scl_q & scl_p & sda_p & ~sda_q;
    wire bus_stop = scl_q & scl_p & ~sda_p & sda_q;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_q <= 1'b1;
            scl_p <= 1'b1;
            sda_q <= 1'b1;
            sda_p <= 1'b1;
        end
        else
        begin
            scl_q <= scl_i;
            scl_p <= scl_q;
            sda_q <= sda_i;
            sda_p <= sda_q;
        end
    end

    // Mode and register reset
    wire reg_mode = config_mode_select;
    wire reg_reset = reg_mode & ~flat_gain_code[1];

    // Register bank
    logic [7:0] pd_q, pd_d;
    logic [7:0] cfg_q [NUM_CH];
    logic [7:0] cfg_d [NUM_CH];
    logic wr_en;
    logic [PTR_W-1:0] wr_idx;
    logic [7:0] wr_data;

    always_comb
    begin
        pd_d = pd_q;
        if (reg_reset)
            pd_d = RST_POWER_DOWN;
        else if (wr_en && wr_idx == IDX_POWER_DOWN)
            pd_d = wr_data;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_cfg
            assign cfg_d[gi] = reg_reset ? RST_CH_CFG :
                (wr_en && wr_idx == rdcr_cfg_idx(gi)) ? wr_data : cfg_q[gi];
            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                    cfg_q[gi] <= RST_CH_CFG;
                else
                    cfg_q[gi] <= cfg_d[gi];
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            pd_q <= RST_POWER_DOWN;
        else
            pd_q <= pd_d;
    end

    // Read mux; reserved and unused bytes read zero
    logic [PTR_W-1:0] ptr_q, ptr_d;
    logic [7:0] rd_byte;
    always_comb
    begin
        unique case (ptr_q)
            IDX_POWER_DOWN: rd_byte = pd_q;
            IDX_CH0_CFG: rd_byte = cfg_q[0];
            IDX_CH1_CFG: rd_byte = cfg_q[1];
            IDX_CH2_CFG: rd_byte = cfg_q[2];
            IDX_CH3_CFG: rd_byte = cfg_q[3];
            default: rd_byte = RSVD_READ;
        endcase
    end

    // Address match
    logic [7:0] sh_q, sh_d;
    wire addr_hit;
    rdcr_addr_match #(
        .SMALL_PKG(SMALL_PKG)
    ) u_addr (
        .addr_rx(sh_q[7:1]),
        .addr_strap(addr_strap),
        .match(addr_hit)
    );

    // Serial slave engine
    rdcr_state_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] tx_q, tx_d;
    logic rw_q, rw_d;
    logic nack_q, nack_d;
    logic oe_q, oe_d;
    wire [PTR_W-1:0] ptr_inc = ptr_q + 4'h1;
    wire ptr_next_ok = (ptr_q != '1);

    always_comb
    begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        tx_d = tx_q;
        rw_d = rw_q;
        nack_d = nack_q;
        oe_d = oe_q;
        ptr_d = ptr_q;
        wr_en = 1'b0;
        wr_idx = ptr_q;
        wr_data = sh_q;
        // Start and stop never coincide
        if (!reg_mode || bus_stop)
        begin
            st_d = RDCR_IDLE;
            oe_d = 1'b0;
        end
        else if (bus_start)
        begin
            st_d = RDCR_ADDR;
            bit_d = '0;
            ptr_d = IDX_RSVD0;
            oe_d = 1'b0;
        end
        else if (scl_rise)
        begin
            if (st_q == RDCR_ADDR || st_q == RDCR_WRITE || st_q == RDCR_READ)
            begin
                sh_d = {sh_q[6:0], sda_q};
                bit_d = bit_q + 4'h1;
            end
            if (st_q == RDCR_READ_ACK)
                nack_d = sda_q;
        end
        else if (scl_fall)
        begin
            unique case (st_q)
                RDCR_ADDR:
                    if (bit_q == BITS_PER_BYTE)
                    begin
                        bit_d = '0;
                        rw_d = sh_q[0];
                        st_d = addr_hit ? RDCR_ADDR_ACK : RDCR_IDLE;
                        oe_d = addr_hit;
                    end
                RDCR_ADDR_ACK:
                    if (rw_q == DIR_READ)
                    begin
                        st_d = RDCR_READ;
                        tx_d = rd_byte;
                        oe_d = ~rd_byte[7];
                    end
                    else
                    begin
                        st_d = RDCR_WRITE;
                        oe_d = 1'b0;
                    end
                RDCR_WRITE:
                    if (bit_q == BITS_PER_BYTE)
                    begin
                        wr_en = 1'b1;
                        bit_d = '0;
                        st_d = RDCR_WRITE_ACK;
                        oe_d = 1'b1;
                        if (ptr_next_ok)
                            ptr_d = ptr_inc;
                    end
                RDCR_WRITE_ACK:
                begin
                    st_d = RDCR_WRITE;
                    oe_d = 1'b0;
                end
                RDCR_READ:
                    if (bit_q == BITS_PER_BYTE)
                    begin
                        bit_d = '0;
                        st_d = RDCR_READ_ACK;
                        oe_d = 1'b0;
                        if (ptr_next_ok)
                            ptr_d = ptr_inc;
                    end
                    else
                    begin
                        tx_d = {tx_q[6:0], 1'b0};
                        oe_d = ~tx_q[6];
                    end
                RDCR_READ_ACK:
                    if (nack_q)
                    begin
                        st_d = RDCR_IDLE;
                        oe_d = 1'b0;
                    end
                    else
                    begin
                        st_d = RDCR_READ;
                        tx_d = rd_byte;
                        oe_d = ~rd_byte[7];
                    end
                default:
                begin
                    st_d = RDCR_IDLE;
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= RDCR_IDLE;
            bit_q <= '0;
            sh_q <= '0;
            tx_q <= '0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
            oe_q <= 1'b0;
            ptr_q <= IDX_RSVD0;
        end
        else
        begin
            st_q <= st_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            rw_q <= rw_d;
            nack_q <= nack_d;
            oe_q <= oe_d;
            ptr_q <= ptr_d;
        end
    end

    // Open-drain pins: only ever pulled low; clock is never stretched
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            scl_oe <= 1'b0;
            global_pd <= 1'b1;
        end
        else
        begin
            sda_o <= 1'b0;
            scl_o <= 1'b0;
            scl_oe <= 1'b0;
            global_pd <= cable_present_n;
        end
    end
    assign sda_oe = oe_q;

    // Per-channel selection
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            rdcr_chan_sel u_ch (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .reg_mode(reg_mode),
                .global_pd(cable_present_n),
                .reg_pd(pd_q[PD_CH0_BIT + gi]),
                .cfg_byte(cfg_q[gi]),
                .strap_eq(equalizer_boost_code),
                .strap_fg(flat_gain_code),
                .strap_sw(output_swing_code),
                .eq_q(ch_eq[gi*EQ_W +: EQ_W]),
                .fg_q(ch_fg[gi*FG_W +: FG_W]),
                .sw_q(ch_sw[gi*SW_W +: SW_W]),
                .enable_q(ch_enable[gi])
            );
        end
    endgenerate
endmodule : rdcr_top

// ### design/rdcr_pkg.sv
// Constants and types shared by the redriver configuration block
package rdcr_pkg;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned NUM_BYTES = 8;
    localparam int unsigned PTR_W = 4;
    // Byte indices
    localparam logic [PTR_W-1:0] IDX_RSVD0 = 4'h0;
    localparam logic [PTR_W-1:0] IDX_RSVD1 = 4'h1;
    localparam logic [PTR_W-1:0] IDX_POWER_DOWN = 4'h2;
    localparam logic [PTR_W-1:0] IDX_CH0_CFG = 4'h3;
    localparam logic [PTR_W-1:0] IDX_CH1_CFG = 4'h4;
    localparam logic [PTR_W-1:0] IDX_CH2_CFG = 4'h5;
    localparam logic [PTR_W-1:0] IDX_CH3_CFG = 4'h6;
    localparam logic [PTR_W-1:0] IDX_RSVD7 = 4'h7;
    // Reset values
    localparam logic [7:0] RST_POWER_DOWN = 8'h00;
    localparam logic [7:0] RST_CH_CFG = 8'h00;
    localparam logic [7:0] RSVD_READ = 8'h00;
    // Field positions
    localparam int unsigned PD_CH0_BIT = 4;
    localparam int unsigned EQ_LSB = 4;
    localparam int unsigned FG_LSB = 2;
    localparam int unsigned SW_LSB = 0;
    localparam int unsigned EQ_W = 4;
    localparam int unsigned FG_W = 2;
    localparam int unsigned SW_W = 2;
    // Bus address: fixed upper bits, then straps
    localparam logic [2:0] ADDR_FIXED = 3'h7;
    localparam logic ADDR_LOW_SMALL = 1'b1;
    localparam logic DIR_READ = 1'b1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        RDCR_IDLE,
        RDCR_ADDR,
        RDCR_ADDR_ACK,
        RDCR_WRITE,
        RDCR_WRITE_ACK,
        RDCR_READ,
        RDCR_READ_ACK
    } rdcr_state_t;

    // Channel configuration byte index for a channel number
    function automatic logic [PTR_W-1:0] rdcr_cfg_idx(input int unsigned ch);
        rdcr_cfg_idx = IDX_CH0_CFG + PTR_W'(ch);
    endfunction : rdcr_cfg_idx
endpackage : rdcr_pkg

// ### design/rdcr_addr_match.sv
// Bus address comparison from fixed bits and address straps
`timescale 1ns/1ps
module rdcr_addr_match
#(
    parameter bit SMALL_PKG = 1'b0
)
(
    // Received address
    input wire logic [6:0] addr_rx,
    // Straps
    input wire logic [3:0] addr_strap,
    // Result
    output logic match
);
    import rdcr_pkg::*;

    wire [6:0] own_addr;
    wire low_bit;

    assign low_bit = SMALL_PKG ? ADDR_LOW_SMALL : addr_strap[0];
    assign own_addr = {ADDR_FIXED, addr_strap[3:1], low_bit};
    assign match = (addr_rx == own_addr);
endmodule : rdcr_addr_match

// ### design/rdcr_chan_sel.sv
// One channel's effective codes and enable, registered
`timescale 1ns/1ps
module rdcr_chan_sel
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Mode and power
    input wire logic reg_mode,
    input wire logic global_pd,
    input wire logic reg_pd,
    // Sources
    input wire logic [7:0] cfg_byte,
    input wire logic [rdcr_pkg::EQ_W-1:0] strap_eq,
    input wire logic [rdcr_pkg::FG_W-1:0] strap_fg,
    input wire logic [rdcr_pkg::SW_W-1:0] strap_sw,
    // Effective settings
    output logic [rdcr_pkg::EQ_W-1:0] eq_q,
    output logic [rdcr_pkg::FG_W-1:0] fg_q,
    output logic [rdcr_pkg::SW_W-1:0] sw_q,
    output logic enable_q
);
    import rdcr_pkg::*;

    wire [EQ_W-1:0] eq_d;
    wire [FG_W-1:0] fg_d;
    wire [SW_W-1:0] sw_d;
    wire enable_d;

    assign eq_d = reg_mode ? cfg_byte[EQ_LSB +: EQ_W] : strap_eq;
    assign fg_d = reg_mode ? cfg_byte[FG_LSB +: FG_W] : strap_fg;
    assign sw_d = reg_mode ? cfg_byte[SW_LSB +: SW_W] : strap_sw;
    assign enable_d = ~global_pd & ~(reg_mode & reg_pd);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            eq_q <= '0;
            fg_q <= '0;
            sw_q <= '0;
            enable_q <= 1'b0;
        end
        else
        begin
            eq_q <= eq_d;
            fg_q <= fg_d;
            sw_q <= sw_d;
            enable_q <= enable_d;
        end
    end
endmodule : rdcr_chan_sel

// ### tb/rdcr_sva.sv
// Assertion checker for the redriver configuration block
`timescale 1ns/1ps
module rdcr_sva
(
    // Clock, reset and bus
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_oe,
    // Mode, presence and straps
    input wire logic cable_present_n,
    input wire logic config_mode_select,
    input wire logic [rdcr_pkg::EQ_W-1:0] equalizer_boost_code,
    input wire logic [rdcr_pkg::SW_W-1:0] output_swing_code,
    input wire logic [rdcr_pkg::FG_W-1:0] flat_gain_code,
    // Channel outputs
    input wire logic [rdcr_pkg::NUM_CH*rdcr_pkg::EQ_W-1:0] ch_eq,
    input wire logic [rdcr_pkg::NUM_CH*rdcr_pkg::FG_W-1:0] ch_fg,
    input wire logic [rdcr_pkg::NUM_CH*rdcr_pkg::SW_W-1:0] ch_sw,
    input wire logic [rdcr_pkg::NUM_CH-1:0] ch_enable,
    input wire logic global_pd
);
    import rdcr_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_absent_all_off: assert property (cable_present_n |=> ch_enable == '0 && global_pd)
        else $error("channel on while cable absent");
    a_present_pd_low: assert property (!cable_present_n |=> !global_pd)
        else $error("power-down while cable present");
    a_strap_eq_all: assert property (!config_mode_select
        |=> ch_eq == {NUM_CH{$past(equalizer_boost_code)}})
        else $error("equalizer differs from strap");
    a_strap_fg_sw: assert property (!config_mode_select
        |=> ch_fg == {NUM_CH{$past(flat_gain_code)}}
        && ch_sw == {NUM_CH{$past(output_swing_code)}})
        else $error("gain or swing differs from strap");
    a_strap_all_on: assert property (!config_mode_select && !cable_present_n
        |=> ch_enable == '1)
        else $error("channel off in strap mode");
    a_strap_no_ack: assert property (!config_mode_select [*4] |-> !sda_oe)
        else $error("bus answered in strap mode");
    a_reg_reset_clear: assert property ((config_mode_select && !flat_gain_code[1]) [*3]
        |-> ch_eq == '0 && ch_fg == '0 && ch_sw == '0
        && ch_enable == {NUM_CH{!$past(cable_present_n)}})
        else $error("registers not cleared by register reset");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i))
        else $error("data line moved while clock high");
    c_ack: cover property ($rose(sda_oe));
    c_cable: cover property ($fell(cable_present_n));
    c_reg_reset: cover property (config_mode_select && !flat_gain_code[1]);
endmodule : rdcr_sva

bind rdcr_top rdcr_sva u_sva (.sys_clk, .rstn, .scl_i, .sda_oe, .cable_present_n,
    .config_mode_select, .equalizer_boost_code, .output_swing_code, .flat_gain_code,
    .ch_eq, .ch_fg, .ch_sw, .ch_enable, .global_pd);

// ### tb/rdcr_host_model.sv
// Serial bus host model for the register port
`timescale 1ns/1ps
module rdcr_host_model
(
    // Clock and bus lines
    input wire logic clk,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out,
    // Read results
    output logic [7:0] rd_byte,
    output logic rd_done
);
    initial
    begin
        scl_out = 1'b1;
        sda_out = 1'b1;
        rd_byte = 8'h00;
        rd_done = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task automatic start();
        sda_out = 1'b1;
        wt(4);
        scl_out = 1'b1;
        wt(8);
        sda_out = 1'b0;
        wt(8);
        scl_out = 1'b0;
        wt(4);
    endtask : start
    // Ends only after a whole byte
    task automatic stop();
        sda_out = 1'b0;
        wt(4);
        scl_out = 1'b1;
        wt(8);
        sda_out = 1'b1;
        wt(8);
    endtask : stop
    // Clock phases kept well above the three-cycle minimum
    task automatic bitx(input logic b, output logic r);
        sda_out = b;
        wt(4);
        scl_out = 1'b1;
        wt(4);
        r = sda_in;
        wt(4);
        scl_out = 1'b0;
        wt(4);
    endtask : bitx
    task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] r,
        output logic nak, input logic rd);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], r[i]);
        bitx(ack, nak);
        if (rd)
        begin
            rd_byte = r;
            rd_done = 1'b1;
            wt(1);
            rd_done = 1'b0;
        end
    endtask : xfer
endmodule : rdcr_host_model

// ### tb/testbench.sv
// Self-checking bench for the redriver configuration block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %s exp %h got %h", nm, e, a); end end
module testbench;
    import rdcr_pkg::*;
    logic sys_clk, rstn, cable_present_n, config_mode_select, nak, rd_done, h_scl, h_sda;
    logic scl_o, scl_oe, sda_o, sda_oe, global_pd, sda_oe_small;
    logic [3:0] addr_strap;
    logic [EQ_W-1:0] equalizer_boost_code;
    logic [SW_W-1:0] output_swing_code;
    logic [FG_W-1:0] flat_gain_code;
    logic [NUM_CH*EQ_W-1:0] ch_eq;
    logic [NUM_CH*FG_W-1:0] ch_fg;
    logic [NUM_CH*SW_W-1:0] ch_sw;
    logic [NUM_CH-1:0] ch_enable;
    logic [7:0] rd_byte, r, ex, c;
    logic [7:0] wd [8];
    logic [7:0] img [8];
    logic [7:0] q [$];
    logic [6:0] dev;
    int n_mismatch = 0;
    int n_tests = 0;
    int seed = 42;
    wire logic scl = h_scl & ~scl_oe;
    wire logic sda = h_sda & ~sda_oe & ~sda_oe_small;
    rdcr_top uut (.sys_clk, .rstn, .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
        .sda_oe, .cable_present_n, .config_mode_select, .addr_strap, .equalizer_boost_code,
        .output_swing_code, .flat_gain_code, .ch_eq, .ch_fg, .ch_sw, .ch_enable, .global_pd);
    rdcr_host_model host (.clk(sys_clk), .sda_in(sda), .scl_out(h_scl), .sda_out(h_sda),
        .rd_byte, .rd_done);
    // Small-package part on the same bus, address bit 0 fixed at one
    rdcr_top #(.SMALL_PKG(1'b1)) uut_small (.sys_clk, .rstn, .scl_i(scl), .scl_o(), .scl_oe(),
        .sda_i(sda), .sda_o(), .sda_oe(sda_oe_small), .cable_present_n, .config_mode_select,
        .addr_strap(addr_strap ^ 4'h3), .equalizer_boost_code, .output_swing_code,
        .flat_gain_code, .ch_eq(), .ch_fg(), .ch_sw(), .ch_enable(), .global_pd());
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    // Every transfer starts at byte 0 and walks upward
    task automatic wr(input int n, input logic ok);
        host.start();
        host.xfer({dev, 1'b0}, 1'b1, r, nak, 1'b0);
        `CHK("wr_ack", !ok, nak)
        for (int k = 0; k < n; k++)
        begin
            host.xfer(wd[k], 1'b1, r, nak, 1'b0);
            if (ok && k > 1 && k < 7)
                img[k] = wd[k];
        end
        host.stop();
    endtask : wr
    task automatic rd(input int n);
        host.start();
        host.xfer({dev, 1'b1}, 1'b1, r, nak, 1'b0);
        `CHK("rd_ack", 1'b0, nak)
        for (int k = 0; k < n; k++)
        begin
            q.push_back(img[k]);
            host.xfer(8'hff, k == n - 1, r, nak, 1'b1);
        end
        host.stop();
    endtask : rd
    always @(posedge rd_done)
    begin
        ex = q.pop_front();
        `CHK("rd_data", ex, rd_byte)
    end
    task automatic chk_out();
        host.wt(3);
        for (int n = 0; n < NUM_CH; n++)
        begin
            c = config_mode_select ? img[3+n]
                : {equalizer_boost_code, flat_gain_code, output_swing_code};
            `CHK("eq", c[7:4], ch_eq[4*n+:4])
            `CHK("fg", c[3:2], ch_fg[2*n+:2])
            `CHK("sw", c[1:0], ch_sw[2*n+:2])
        end
        c[3:0] = config_mode_select ? ~img[2][7:4] : 4'hf;
        `CHK("en", cable_present_n ? 4'h0 : c[3:0], ch_enable)
        `CHK("gpd", cable_present_n, global_pd)
        `CHK("pins", 3'h0, {scl_o, scl_oe, sda_o})
    endtask : chk_out
    initial
    begin
        rstn = 1'b0;
        cable_present_n = 1'b0;
        config_mode_select = 1'b1;
        addr_strap = 4'($random(seed));
        equalizer_boost_code = 4'h0;
        output_swing_code = 2'h0;
        flat_gain_code = 2'h3;
        foreach (img[k])
            img[k] = 8'h00;
        dev = {ADDR_FIXED, addr_strap};
        repeat (16) @(posedge sys_clk);
        #1 rstn = 1'b1;
        host.wt(3);
        rd(8);
        chk_out();
        for (int t = 0; t < 4; t++)
        begin
            foreach (wd[k])
                wd[k] = 8'($random(seed)) & 8'hfe;
            wr(t == 3 ? 3 : 8, 1'b1);
            rd(t == 3 ? 5 : 8);
            chk_out();
        end
        dev = dev ^ 7'h01;
        wr(8, 1'b0);
        dev = {ADDR_FIXED, addr_strap[3:1] ^ 3'h1, 1'b1};
        wr(0, 1'b1);
        dev[0] = 1'b0;
        wr(0, 1'b0);
        dev = {ADDR_FIXED, addr_strap};
        rd(8);
        cable_present_n = 1'b1;
        chk_out();
        cable_present_n = 1'b0;
        chk_out();
        config_mode_select = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            equalizer_boost_code = 4'(i);
            flat_gain_code = 2'(i);
            output_swing_code = 2'(i >> 2);
            chk_out();
        end
        wr(3, 1'b0);
        config_mode_select = 1'b1;
        chk_out();
        flat_gain_code = 2'h1;
        host.wt(4);
        flat_gain_code = 2'h3;
        foreach (img[k])
            img[k] = 8'h00;
        rd(8);
        chk_out();
        end_sim();
    end
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        end_sim();
    end
endmodule : testbench
